// File: timer_map.vh
// Purpose: Register map, field positions and reset values of the timer.
// Assumes: Word-aligned 32-bit registers on an AHB-Lite slave.
// Notes: Definitions only.
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH

// Byte offsets
`define OFS_START    8'h00
`define OFS_MODE0    8'h04
`define OFS_MODE1    8'h08
`define OFS_MODE2    8'h0c
`define OFS_COUNT0   8'h10
`define OFS_COUNT1   8'h14
`define OFS_COUNT2   8'h18
`define OFS_STATUS   8'h1c

// Shared start register: run flags of channels 0..2
`define RUN_LSB      5
`define RUN_MSB      7

// Channel mode register fields
`define MODE_LSB     0
`define MODE_MSB     1
`define EDGE_BIT     2
`define EVSRC_BIT    3
`define CSEL_LSB     4
`define CSEL_MSB     6

// Operating modes
`define MODE_TIMER   2'h0
`define MODE_EVENT   2'h1
`define MODE_PULSE   2'h2
`define MODE_TRIG    2'h3

// Count source select values
`define CSEL_DIV1    3'h0
`define CSEL_DIV2    3'h1
`define CSEL_DIV8    3'h2
`define CSEL_DIV32   3'h3
`define CSEL_SUB32   3'h4

// Prescaler terminal counts
`define PRE_DIV2_MASK  5'h01
`define PRE_DIV8_MASK  5'h07
`define PRE_DIV32_MASK 5'h1f

// Reset values
`define START_RST    8'h00
`define MODE_RST     8'h00
`define COUNT_RST    16'h0000

// AHB transfer type and response
`define HTRANS_NONSEQ 2'h2
`define HRESP_OKAY    1'b0

`endif

// File: down_channel.v
// Purpose: One 16-bit reloading down counter with underflow pulse.
// Assumes: tick is a one-cycle count event already gated by mode.
// Notes: Write to the count register follows the first-event rule.
module down_channel #(
  parameter WIDTH = 16
) (
  input wire clk,              // System clock
  input wire rst_n,            // Async reset, active low
  input wire run,              // Channel run flag
  input wire tick,             // Count-source event, one cycle
  input wire wr,               // Count register write strobe
  input wire [WIDTH-1:0] wdata, // Value written
  output reg [WIDTH-1:0] count_r, // Live counter
  output reg [WIDTH-1:0] reload_r, // Reload register
  output reg started_r,        // First event of this run seen
  output reg uf_r              // Underflow pulse
);

  wire counting;
  wire early;

  assign counting = run & tick;
  // Before the first event the counter itself is still open to writes
  assign early = ~run | ~started_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= {WIDTH{1'b0}};
      reload_r <= {WIDTH{1'b0}};
      started_r <= 1'b0;
      uf_r <= 1'b0;
    end else begin
      uf_r <= 1'b0;
      if (!run) begin
        started_r <= 1'b0;                        // [R06]
      end else if (tick) begin
        started_r <= 1'b1;
      end
      if (wr) begin
        reload_r <= wdata;                        // [R10]
      end
      if (wr && early) begin
        count_r <= wdata;                         // [R09]
      end else if (counting) begin
        if (count_r == {WIDTH{1'b0}}) begin
          // n+1 events per underflow, n = 0 included
          count_r <= wr ? wdata : reload_r;       // [R03] [R04] [R10]
          uf_r <= 1'b1;                           // [R07]
        end else begin
          count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1}; // [R03]
        end
      end
    end
  end

endmodule

// File: three_channel_down_counter_timer.v
// Purpose: Three 16-bit down-counting timer channels behind AHB-Lite.
// Assumes: One clock; pins and sub-clock synchronous-safe via syncs.
// Notes: Zero-wait slave; unmapped reads return zero.
//
// Summary of operation
// [R01] Each channel picks one of four modes by a two-bit field.
// [R02] Timer mode counts clk_div1, clk_div2, clk_div8, clk_div32 or subclk_div32.
// [R03] Counter decrements per event; on underflow reloads and keeps counting.
// [R04] Loaded value n gives one underflow every n+1 events.
// [R05] Run flags sit in start register bits 5, 6 and 7.
// [R06] Writing 1 starts a channel; writing 0 halts it holding its value.
// [R07] Each underflow raises the channel interrupt request.
// [R08] Reading the count register returns the live counter.
// [R09] Write while stopped or before first event loads reload and counter.
// [R10] Write after first event loads reload only; counter takes it next.
// [R11] Event mode counts own pin edges or previous channel underflow.
// [R12] Software picks the active edge of the event input.
// [R13] Software accesses count registers only as whole 16-bit words.
// [R14] In timer mode the event pin plays no part in counting.
// [R15] Pulse-measure and trigger modes are decoded but leave counter idle.
// [R16] Pin edges are synchronised and cut to one-cycle count pulses.
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`include "timer_map.vh"

module three_channel_down_counter_timer #(
  parameter CNT_W = 16,
  parameter NCH = 3
) (
  input wire hclk,               // System clock, 100 MHz
  input wire hresetn,            // Async reset, active low
  input wire hsel,               // Slave select
  input wire [31:0] haddr,       // Byte address
  input wire [1:0] htrans,       // Transfer type
  input wire hwrite,             // 1 = write
  input wire [2:0] hsize,        // Transfer size
  input wire hready,             // Bus ready in
  input wire [31:0] hwdata,      // Write data
  output reg [31:0] hrdata_r,    // Read data
  output reg hreadyout_r,        // Slave ready
  output reg hresp_r,            // Response, always OKAY
  input wire sub_clk,            // Sub-clock, sampled as a level
  input wire [NCH-1:0] ev_in,    // Channel event inputs
  output reg [NCH-1:0] irq_r,    // Underflow interrupt requests
  output reg [NCH-1:0] pin_gpio_r // Pin free for port use
);

  // Bus capture of the address phase
  localparam BUS_IDLE = 2'b01;
  localparam BUS_WDATA = 2'b10;
  reg [1:0] bus_st_r;
  reg [1:0] bus_st_nxt;
  wire wr_pend;
  reg [7:0] wr_addr_r;
  wire take;
  wire [7:0] a;

  // Software registers
  reg [7:0] start_r;
  reg [7:0] mode_r [0:NCH-1];

  // Prescaler and sub-clock divider
  reg [4:0] pre_r;
  reg sub_s1_r;
  reg sub_s2_r;
  reg sub_s3_r;
  reg [4:0] sub_cnt_r;
  wire sub_rise;
  wire tick_d1;
  wire tick_d2;
  wire tick_d8;
  wire tick_d32;
  wire tick_s32;

  // Event input synchronisers
  reg [NCH-1:0] ev_s1_r;
  reg [NCH-1:0] ev_s2_r;
  reg [NCH-1:0] ev_s3_r;
  reg [NCH-1:0] ev_pulse_r;
  wire [NCH-1:0] ev_rise;
  wire [NCH-1:0] ev_fall;

  // Channel wiring
  wire [NCH-1:0] run;
  wire [NCH-1:0] tick;
  wire [NCH-1:0] wr_cnt;
  wire [NCH-1:0] uf;
  wire [NCH-1:0] started;
  wire [CNT_W-1:0] count [0:NCH-1];

  reg [31:0] rd_nxt;

  // One loop index per process, so no variable has two drivers
  integer i_mode;
  integer i_ev;
  integer i_pin;

  assign take = hsel & hready & (htrans == `HTRANS_NONSEQ);
  assign a = haddr[7:0];

  // Address phase capture; hreadyout stays high so every access is
  // zero-wait and read data is staged for the data phase.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r <= `HRESP_OKAY;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r <= `HRESP_OKAY;
      if (hready) begin
        wr_addr_r <= a;
      end
      if (take && !hwrite) begin
        hrdata_r <= rd_nxt;
      end
    end
  end

  // Writes are tracked as a state so the register decode runs only in
  // the data phase, when hwdata is valid.
  always @* begin
    bus_st_nxt = bus_st_r;
    case (bus_st_r)
      BUS_IDLE: begin
        if (take && hwrite) begin
          bus_st_nxt = BUS_WDATA;
        end
      end
      BUS_WDATA: begin
        if (hready) begin
          bus_st_nxt = (take && hwrite) ? BUS_WDATA : BUS_IDLE;
        end
      end
      default: bus_st_nxt = BUS_IDLE;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st_r <= BUS_IDLE;
    end else begin
      bus_st_r <= bus_st_nxt;
    end
  end

  assign wr_pend = (bus_st_r == BUS_WDATA);

  // Read decode of live state
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (a)
      `OFS_START: rd_nxt = {24'h00_0000, start_r};
      `OFS_MODE0: rd_nxt = {24'h00_0000, mode_r[0]};
      `OFS_MODE1: rd_nxt = {24'h00_0000, mode_r[1]};
      `OFS_MODE2: rd_nxt = {24'h00_0000, mode_r[2]};
      `OFS_COUNT0: rd_nxt = {16'h0000, count[0]};   // [R08]
      `OFS_COUNT1: rd_nxt = {16'h0000, count[1]};   // [R08]
      `OFS_COUNT2: rd_nxt = {16'h0000, count[2]};   // [R08]
      `OFS_STATUS: rd_nxt = {26'h000_0000, ev_s2_r, started};
      default: rd_nxt = 32'h0000_0000;
    endcase
    // A read right behind a write to the same register sees the value
    // just written. Count reads may still lag the write by one cycle.
    if (wr_pend && (wr_addr_r == a)) begin
      case (a)
        `OFS_START: begin
          rd_nxt = {24'h00_0000, hwdata[`RUN_MSB:`RUN_LSB], 5'h00};
        end
        `OFS_MODE0, `OFS_MODE1, `OFS_MODE2: begin
          rd_nxt = {25'h000_0000, hwdata[6:0]};
        end
        default: begin
        end
      endcase
    end
  end

  // Register writes in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_r <= `START_RST;
      for (i_mode = 0; i_mode < NCH; i_mode = i_mode + 1) begin
        mode_r[i_mode] <= `MODE_RST;
      end
    end else if (wr_pend) begin
      case (wr_addr_r)
        `OFS_START: begin
          // Only the run flags are storage; other bits read zero
          start_r <= {hwdata[`RUN_MSB:`RUN_LSB], 5'h00};  // [R05] [R06]
        end
        `OFS_MODE0: mode_r[0] <= {1'b0, hwdata[6:0]};     // [R01]
        `OFS_MODE1: mode_r[1] <= {1'b0, hwdata[6:0]};     // [R01]
        `OFS_MODE2: mode_r[2] <= {1'b0, hwdata[6:0]};     // [R01]
        default: start_r <= start_r;
      endcase
    end
  end

  // Count register writes take the low half-word as one unit, so a
  // value never lands half old and half new.
  assign wr_cnt[0] = wr_pend & (wr_addr_r == `OFS_COUNT0); // [R13]
  assign wr_cnt[1] = wr_pend & (wr_addr_r == `OFS_COUNT1); // [R13]
  assign wr_cnt[2] = wr_pend & (wr_addr_r == `OFS_COUNT2); // [R13]

  // Free-running prescaler for the internal count sources
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= 5'h00;
    end else begin
      pre_r <= pre_r + 5'h01;
    end
  end

  assign tick_d1 = 1'b1;
  assign tick_d2 = (pre_r & `PRE_DIV2_MASK) == `PRE_DIV2_MASK;
  assign tick_d8 = (pre_r & `PRE_DIV8_MASK) == `PRE_DIV8_MASK;
  assign tick_d32 = pre_r == `PRE_DIV32_MASK;

  // Sub-clock: synchronised, rising edges divided by 32. The sub-clock
  // must run well below hclk / 2 or edges are missed.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub_s1_r <= 1'b0;
      sub_s2_r <= 1'b0;
      sub_s3_r <= 1'b0;
      sub_cnt_r <= 5'h00;
    end else begin
      sub_s1_r <= sub_clk;
      sub_s2_r <= sub_s1_r;
      sub_s3_r <= sub_s2_r;
      if (sub_rise) begin
        sub_cnt_r <= sub_cnt_r + 5'h01;
      end
    end
  end

  assign sub_rise = sub_s2_r & ~sub_s3_r;
  assign tick_s32 = sub_rise & (sub_cnt_r == `PRE_DIV32_MASK);

  // Event pins: two-flop sync, then edge select to a single pulse
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_s1_r <= {NCH{1'b0}};
      ev_s2_r <= {NCH{1'b0}};
      ev_s3_r <= {NCH{1'b0}};
      ev_pulse_r <= {NCH{1'b0}};
    end else begin
      ev_s1_r <= ev_in;                                   // [R16]
      ev_s2_r <= ev_s1_r;                                 // [R16]
      ev_s3_r <= ev_s2_r;
      for (i_ev = 0; i_ev < NCH; i_ev = i_ev + 1) begin
        if (mode_r[i_ev][`EDGE_BIT]) begin
          ev_pulse_r[i_ev] <= ev_rise[i_ev];              // [R12] [R16]
        end else begin
          ev_pulse_r[i_ev] <= ev_fall[i_ev];              // [R12] [R16]
        end
      end
    end
  end

  // Edge candidates from the second and third sync stages only; the
  // pulse flop adds a cycle, so a pin edge counts four edges later.
  assign ev_rise = ev_s2_r & ~ev_s3_r;                    // [R16]
  assign ev_fall = ~ev_s2_r & ev_s3_r;                    // [R16]

  // Pin is free for port use unless the channel counts it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_gpio_r <= {NCH{1'b1}};
    end else begin
      for (i_pin = 0; i_pin < NCH; i_pin = i_pin + 1) begin
        pin_gpio_r[i_pin] <=
          ~((mode_r[i_pin][`MODE_MSB:`MODE_LSB] == `MODE_EVENT)
            & ~mode_r[i_pin][`EVSRC_BIT]);                 // [R14]
      end
    end
  end

  // Interrupt is a registered copy of the one-cycle underflow pulse
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= {NCH{1'b0}};
    end else begin
      irq_r <= uf;                                        // [R07]
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      wire [1:0] md;
      wire [2:0] csel;
      reg tick_int;
      wire tick_ev;
      wire chain_uf;
      wire is_timer;
      wire is_event;

      assign md = mode_r[g][`MODE_MSB:`MODE_LSB];
      assign csel = mode_r[g][`CSEL_MSB:`CSEL_LSB];
      assign run[g] = start_r[`RUN_LSB + g];               // [R05]

      // Internal source selection
      always @* begin
        case (csel)
          `CSEL_DIV1: tick_int = tick_d1;                  // [R02]
          `CSEL_DIV2: tick_int = tick_d2;                  // [R02]
          `CSEL_DIV8: tick_int = tick_d8;                  // [R02]
          `CSEL_DIV32: tick_int = tick_d32;                // [R02]
          `CSEL_SUB32: tick_int = tick_s32;                // [R02]
          default: tick_int = 1'b0;
        endcase
      end

      // Channel 0 is chained from the last channel
      assign chain_uf = uf[(g + NCH - 1) % NCH];           // [R11]
      assign tick_ev = mode_r[g][`EVSRC_BIT] ? chain_uf
                                              : ev_pulse_r[g]; // [R11]

      // Pulse-measure and trigger encodings hold the counter idle;
      // the pin is ignored in timer mode.
      assign is_timer = (md == `MODE_TIMER);
      assign is_event = (md == `MODE_EVENT);
      assign tick[g] = is_timer ? tick_int                 // [R01] [R14]
                     : is_event ? tick_ev                  // [R01]
                     : 1'b0;                               // [R15]

      down_channel #(
        .WIDTH(CNT_W)
      ) u_chan (
        .clk(hclk),
        .rst_n(hresetn),
        .run(run[g]),
        .tick(tick[g]),
        .wr(wr_cnt[g]),
        .wdata(hwdata[CNT_W-1:0]),
        .count_r(count[g]),
        .reload_r(),
        .started_r(started[g]),
        .uf_r(uf[g])
      );
    end
  endgenerate

endmodule

// File: timer_asserts.sv
// Purpose: Port-level checks of the three-channel down counter timer.
// Assumes: Zero-wait slave; register writes land at the data-phase edge.
// Notes: Mode and run shadows are rebuilt from bus traffic only.
`include "timer_map.vh"
module timer_asserts #(
  parameter NCH = 3
) (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write flag
  input wire logic [2:0] hsize, // Size
  input wire logic hready, // Bus ready
  input wire logic [31:0] hwdata, // Write data
  input wire logic [31:0] hrdata_r, // Read data
  input wire logic hreadyout_r, // Slave ready
  input wire logic hresp_r, // Response
  input wire logic sub_clk, // Sub-clock
  input wire logic [NCH-1:0] ev_in, // Event pins
  input wire logic [NCH-1:0] irq_r, // Interrupt pulses
  input wire logic [NCH-1:0] pin_gpio_r // Pin free flags
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_ph;
  logic [7:0] wa;
  logic [2:0] run_sh;
  logic [3:0] msh [NCH];
  logic [NCH-1:0] gp_exp;
  wire take = hsel && hready && htrans == `HTRANS_NONSEQ;
  wire rd_take = take && !hwrite;
  wire [11:0] mflat = {msh[2], msh[1], msh[0]};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      wa <= 8'h00;
      run_sh <= 3'h0;
      for (int i = 0; i < NCH; i++)
        msh[i] <= 4'h0;
    end else begin
      wr_ph <= take && hwrite;
      wa <= haddr[7:0];
      if (wr_ph && wa == `OFS_START)
        run_sh <= hwdata[7:5];
      for (int i = 0; i < NCH; i++)
        if (wr_ph && wa == `OFS_MODE0 + 8'(4 * i))
          msh[i] <= hwdata[3:0];
    end
  end
  // Pin is only claimed by event mode with pin source
  always_comb begin
    for (int i = 0; i < NCH; i++)
      gp_exp[i] = !(msh[i][1:0] == `MODE_EVENT && !msh[i][3]);
  end
  sequence s_rd_start;
    rd_take && haddr[7:0] == `OFS_START;
  endsequence
  sequence s_quiet;
    $stable(mflat) [*3];
  endsequence
  property p_ready;
    hreadyout_r;
  endproperty
  property p_okay;
    hresp_r == `HRESP_OKAY;
  endproperty
  property p_unmapped;
    rd_take && haddr[7:0] > `OFS_STATUS |=> hrdata_r == 32'h0;
  endproperty
  property p_start_rd;
    s_rd_start |=> hrdata_r[7:5] == run_sh;
  endproperty
  property p_stand;
    !rd_take |=> $stable(hrdata_r);
  endproperty
  property p_gpio;
    s_quiet |-> pin_gpio_r == gp_exp;
  endproperty
  property p_irq_run(int i);
    irq_r[i] |-> $past(run_sh[i], 2);
  endproperty
  property p_irq_mode(int i);
    irq_r[i] |-> $past(msh[i][1], 2) == 1'b0;
  endproperty
  a_ready: assert property (p_ready)
    else $error("slave ready dropped");
  a_okay: assert property (p_okay)
    else $error("response not okay");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_start_rd: assert property (p_start_rd)
    else $error("run flags read wrong");
  a_stand: assert property (p_stand)
    else $error("read data moved");
  a_gpio: assert property (p_gpio)
    else $error("pin use flag wrong");
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    a_irq_run: assert property (p_irq_run(i))
      else $error("interrupt while halted");
    a_irq_mode: assert property (p_irq_mode(i))
      else $error("interrupt in idle mode");
  end
endmodule

// File: pulse_source.sv
// Purpose: Far-side source that flips one event pin on request.
// Assumes: The pin is a plain level that holds between requests.
// Notes: Each flip comes a few cycles after the request.
module pulse_source #(
  parameter DLY = 3
) (
  input wire logic clk, // System clock
  input wire logic go, // Request one flip
  output logic pin // Event pin level
);
  logic [3:0] k;
  initial begin
    pin = 1'b0;
    k = 4'h0;
  end
  always @(posedge clk) begin
    if (go)
      k <= 4'(DLY);
    else if (k != 4'h0)
      k <= k - 4'h1;
    // One clean transition, held long past the input sync
    if (k == 4'h1)
      pin <= ~pin;
  end
endmodule

// File: three_channel_down_counter_timer_test.sv
// Purpose: Bus-level test of the three-channel down counter timer.
// Assumes: Zero-wait slave; sub-clock period of six system cycles.
// Notes: Gaps between interrupt pulses give the division ratios.
`include "timer_map.vh"
module three_channel_down_counter_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic sub_clk = 1'b0, go = 1'b0, pin, hreadyout_r, hresp_r;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata_r, q, q2, q3;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, irq_r, pin_gpio_r;
  int errors = 0, total_checks = 0;
  int div [5] = '{1, 2, 8, 32, 192};
  always #5 hclk = ~hclk;
  int sc = 0;
  always @(posedge hclk) begin
    sc <= (sc == 2) ? 0 : sc + 1;
    if (sc == 2)
      sub_clk <= ~sub_clk;
  end
  three_channel_down_counter_timer dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout_r), .hwdata(hwdata),
    .hrdata_r(hrdata_r), .hreadyout_r(hreadyout_r), .hresp_r(hresp_r),
    .sub_clk(sub_clk), .ev_in({1'b0, pin, 1'b0}), .irq_r(irq_r),
    .pin_gpio_r(pin_gpio_r));
  pulse_source src (.clk(hclk), .go(go), .pin(pin));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic stuck;
    errors++;
    $display("BAD wait exp done got timeout");
    report_and_stop();
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= `HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout_r !== 1'b1 && k < 9);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d; // Whole words only
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout_r !== 1'b1 && k < 9);
    r = hrdata_r;
    if (k >= 9)
      stuck();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, q2);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input int e);
    xfer(1'b0, a, 32'h0, q);
    chk(n, 32'(e), q);
  endtask
  // Skip one partial and one full period, then measure the next full one
  task automatic gapc(input int ch, input int e);
    int k, n;
    k = 0;
    repeat (3) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
        k++;
      end while (irq_r[ch] !== 1'b1 && k < 3000);
    end
    if (k >= 3000)
      stuck();
    chk("gap", 32'(e), 32'(n));
  endtask
  task automatic flip(input int e);
    @(posedge hclk);
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    repeat (12) @(posedge hclk);
    rdc("cnt1", `OFS_COUNT1, e);
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("start", `OFS_START, 0);
    wr(8'h20, 32'hff);
    rdc("hole", 8'h20, 0);
    wr(`OFS_START, 32'hff);
    xfer(1'b0, `OFS_START, 32'h0, q);
    chk("run", 32'h7, {29'h0, q[7:5]});
    wr(`OFS_START, 32'h0);
    wr(`OFS_COUNT0, 32'hf);
    rdc("load", `OFS_COUNT0, 15);
    wr(`OFS_START, 32'h20);
    gapc(0, 16);
    wr(`OFS_COUNT0, 32'h1f);
    xfer(1'b0, `OFS_COUNT0, 32'h0, q);
    chk("keep", 32'h1, {31'h0, q[15:0] < 16'h0010});
    gapc(0, 32);
    xfer(1'b0, `OFS_COUNT0, 32'h0, q);
    xfer(1'b0, `OFS_COUNT0, 32'h0, q3);
    chk("live", (q + 32'h1d) % 32'h20, q3);
    wr(`OFS_START, 32'h0);
    xfer(1'b0, `OFS_COUNT0, 32'h0, q);
    xfer(1'b0, `OFS_COUNT0, 32'h0, q3);
    chk("halt", q, q3);
    for (int c = 0; c < 5; c++) begin
      wr(`OFS_START, 32'h0);
      wr(`OFS_MODE0, 32'(c) << 4);
      wr(`OFS_COUNT0, 32'h1);
      wr(`OFS_START, 32'h20);
      gapc(0, 2 * div[c]);
    end
    for (int m = 2; m < 4; m++) begin
      wr(`OFS_START, 32'h0);
      wr(`OFS_MODE0, 32'(m));
      wr(`OFS_COUNT0, 32'h3);
      wr(`OFS_START, 32'h20);
      repeat (40) @(posedge hclk);
      rdc("idle", `OFS_COUNT0, 3);
    end
    wr(`OFS_START, 32'h0);
    wr(`OFS_MODE1, 32'h5);
    wr(`OFS_COUNT1, 32'h5);
    wr(`OFS_START, 32'h40);
    flip(4);
    wr(`OFS_MODE1, 32'h1);
    flip(3);
    flip(3);
    wr(`OFS_MODE1, 32'h50);
    flip(3);
    wr(`OFS_START, 32'h0);
    wr(`OFS_MODE2, 32'h0);
    wr(`OFS_COUNT2, 32'h1);
    wr(`OFS_MODE0, 32'h9);
    wr(`OFS_COUNT0, 32'h3);
    wr(`OFS_START, 32'ha0);
    gapc(0, 8);
    report_and_stop();
  end
endmodule
bind three_channel_down_counter_timer timer_asserts #(.NCH(NCH)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .hwdata(hwdata), .hrdata_r(hrdata_r), .hreadyout_r(hreadyout_r),
  .hresp_r(hresp_r), .sub_clk(sub_clk), .ev_in(ev_in), .irq_r(irq_r),
  .pin_gpio_r(pin_gpio_r));
